//--- hdl/byte_fifo.sv
`timescale 1ns/1ps
// Memory FIFO with a registered output stage, so read data comes from a flop
module byte_fifo #(
    parameter int  WIDTH = 8,
    parameter int  DEPTH = 128,
    localparam int AW    = $clog2(DEPTH),
    localparam int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             wr_valid,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  wr_ready,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data,
    output logic [CW-1:0]         level
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0]    mem_count_reg, mem_count_next;
    logic             out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg, out_data_next;
    logic             push;
    logic             pop;
    logic             load;

    always_comb begin
        level          = mem_count_reg + CW'(out_valid_reg);
        wr_ready       = level < CW'(DEPTH);
        push           = wr_valid && wr_ready;
        pop            = out_valid_reg && rd_ready;
        load           = (mem_count_reg != '0) && (!out_valid_reg || pop);
        wr_ptr_next    = wr_ptr_reg;
        rd_ptr_next    = rd_ptr_reg;
        out_data_next  = out_data_reg;
        out_valid_next = load ? 1'b1 : (pop ? 1'b0 : out_valid_reg);
        mem_count_next = mem_count_reg + CW'(push) - CW'(load);
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
        end
        if (load) begin
            out_data_next = mem[rd_ptr_reg];
            rd_ptr_next   = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            mem_count_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else begin
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            mem_count_reg <= mem_count_next;
            out_valid_reg <= out_valid_next;
            out_data_reg  <= out_data_next;
        end
    end

    // Storage is not reset; emptiness is carried by the counters
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr_data;
        end
    end

    assign rd_valid = out_valid_reg;
    assign rd_data  = out_data_reg;

endmodule : byte_fifo

//--- hdl/frame_sync_rx_pkg.sv
package frame_sync_rx_pkg;

    localparam int          BYTE_W          = 8;
    localparam int          FIFO_DEPTH      = 128;
    localparam int          SPACE_THRESH    = 64;
    localparam int          SYS_PERIOD_NS   = 100;
    localparam int          MIN_GAP_PERIODS = 256;
    // Host-side spacing, used by the host model to space frames
    localparam int          MIN_GAP_NS      = MIN_GAP_PERIODS * SYS_PERIOD_NS;
    localparam int          MIN_GAP_CYC     = (MIN_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int          CLK_RATIO_MIN   = 4;
    localparam logic [2:0]  BIT_CNT_RESET   = 3'h0;
    localparam logic [2:0]  BIT_CNT_AFTER   = 3'h1;
    localparam logic [2:0]  BIT_CNT_LAST    = 3'h7;

    typedef struct packed {
        logic frame_sync;
        logic serial_data_in;
    } link_pins_t;

    typedef logic [BYTE_W-1:0] byte_t;

endpackage : frame_sync_rx_pkg

//--- hdl/serial_slave_sync_receiver.sv
`timescale 1ns/1ps
module serial_slave_sync_receiver #(
    parameter int  FIFO_DEPTH   = frame_sync_rx_pkg::FIFO_DEPTH,
    parameter int  SPACE_THRESH = frame_sync_rx_pkg::SPACE_THRESH,
    localparam int CW           = $clog2(FIFO_DEPTH + 1)
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     serial_in_clock,
    input  wire frame_sync_rx_pkg::link_pins_t link_pins,
    input  wire logic                     fuse_serial_boot,
    input  wire logic                     rd_ready,
    output logic                          rd_valid,
    output frame_sync_rx_pkg::byte_t           rd_data,
    output logic                          fifo_space_flag_n
);

    // Only the space flag goes back to the host

    // ---------------- Link domain ----------------
    logic                lrst_n_s1_reg;
    logic                lrst_n_s2_reg;
    logic                sync_prev_reg, sync_prev_next;
    logic [2:0]          bit_count_reg, bit_count_next;
    logic [6:0]          shift_reg, shift_next;
    frame_sync_rx_pkg::byte_t held_byte_reg, held_byte_next;
    logic                done_tgl_reg, done_tgl_next;
    logic                sync_rise;
    logic                sdi;

    assign sdi = link_pins.serial_data_in;

    // System reset brought onto the link clock; link clock may stop between frames
    always_ff @(posedge serial_in_clock) begin
        lrst_n_s1_reg <= rst_n;
        lrst_n_s2_reg <= lrst_n_s1_reg;
    end

    always_comb begin
        sync_rise      = link_pins.frame_sync && !sync_prev_reg;
        sync_prev_next = link_pins.frame_sync;
        held_byte_next = held_byte_reg;
        done_tgl_next  = done_tgl_reg;
        if (!lrst_n_s2_reg) begin
            bit_count_next = frame_sync_rx_pkg::BIT_CNT_RESET;
            shift_next     = '0;
            sync_prev_next = 1'b0;
            // Toggle step reaches clk side while its own reset still holds
            held_byte_next = '0;
            done_tgl_next  = 1'b0;
        end else if (sync_rise) begin
            bit_count_next = frame_sync_rx_pkg::BIT_CNT_AFTER;
            shift_next     = {6'h00, sdi};
        end else begin
            bit_count_next = bit_count_reg + 3'h1;
            shift_next     = {shift_reg[5:0], sdi};
            if (bit_count_reg == frame_sync_rx_pkg::BIT_CNT_LAST) begin
                held_byte_next = {shift_reg, sdi};
                done_tgl_next  = !done_tgl_reg;
            end
        end
    end

    // Held byte stays still for 8 link edges, far longer than the crossing needs
    always_ff @(posedge serial_in_clock) begin
        bit_count_reg <= bit_count_next;
        shift_reg     <= shift_next;
        sync_prev_reg <= sync_prev_next;
        held_byte_reg <= held_byte_next;
        done_tgl_reg  <= done_tgl_next;
    end

    // ---------------- System domain ----------------
    logic                tgl_s1_reg;
    logic                tgl_s2_reg;
    logic                tgl_s3_reg;
    logic                fuse_s1_reg;
    logic                fuse_s2_reg;
    logic                port_en_reg, port_en_next;
    logic                flag_reg, flag_next;
    logic                byte_event;
    logic                wr_valid;
    logic                wr_ready;
    logic [CW-1:0]       level;

    always_ff @(posedge clk) begin
        tgl_s1_reg  <= done_tgl_reg;
        tgl_s2_reg  <= tgl_s1_reg;
        tgl_s3_reg  <= tgl_s2_reg;
        fuse_s1_reg <= fuse_serial_boot;
        fuse_s2_reg <= fuse_s1_reg;
    end

    always_comb begin
        byte_event   = tgl_s2_reg ^ tgl_s3_reg;
        // Fuse is sampled only while reset holds; later changes are ignored
        port_en_next = !rst_n ? fuse_s2_reg : port_en_reg;
        wr_valid     = byte_event && port_en_reg;
        flag_next    = level >= CW'(SPACE_THRESH);
    end

    always_ff @(posedge clk) begin
        port_en_reg <= port_en_next;
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // A full FIFO refuses the write, so the byte is simply lost
    byte_fifo #(
        .WIDTH (frame_sync_rx_pkg::BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .wr_valid (wr_valid),
        .wr_data  (held_byte_reg),
        .wr_ready (wr_ready),
        .rd_valid (rd_valid),
        .rd_ready (rd_ready),
        .rd_data  (rd_data),
        .level    (level)
    );

    assign fifo_space_flag_n = flag_reg;

    // ---------------- Checks ----------------
    logic pop;
    assign pop = rd_valid && rd_ready;

    sequence s_byte_done;
        $changed(done_tgl_reg);
    endsequence

    sequence s_msb_placed;
        held_byte_reg[7] == $past(sdi, 8) && held_byte_reg[0] == $past(sdi, 1);
    endsequence

    property p_msb_first;
        @(posedge serial_in_clock) disable iff (!lrst_n_s2_reg)
        s_byte_done |-> s_msb_placed;
    endproperty

    a_msb_first_order: assert property (p_msb_first)
        else $error("received byte not assembled MSB first");

    a_bit_each_edge: assert property (
        @(posedge serial_in_clock) disable iff (!lrst_n_s2_reg)
        (lrst_n_s2_reg && !(link_pins.frame_sync && !sync_prev_reg))
        |=> bit_count_reg == $past(bit_count_reg) + 3'h1)
        else $error("bit counter did not advance on serial clock edge");

    a_sync_restart: assert property (
        @(posedge serial_in_clock) disable iff (!lrst_n_s2_reg)
        (link_pins.frame_sync && !sync_prev_reg)
        |=> bit_count_reg == frame_sync_rx_pkg::BIT_CNT_AFTER && shift_reg[0] == $past(sdi))
        else $error("frame sync did not restart byte at MSB");

    a_link_reset_clear: assert property (
        @(posedge serial_in_clock)
        !lrst_n_s2_reg |=> bit_count_reg == frame_sync_rx_pkg::BIT_CNT_RESET)
        else $error("bit counter not cleared by reset");

    a_fifo_push: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_valid && wr_ready && !pop) |=> level == $past(level) + CW'(1))
        else $error("completed byte not stored");

    a_full_drop: assert property (
        @(posedge clk) disable iff (!rst_n)
        (byte_event && !wr_ready && !pop) |=> level == $past(level))
        else $error("byte at full FIFO changed contents");

    a_space_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        ##1 fifo_space_flag_n == ($past(level) >= CW'(SPACE_THRESH)))
        else $error("space flag does not follow FIFO level");

    a_byte_unchanged: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_valid && level == '0) |-> ##2 (rd_valid && rd_data == $past(held_byte_reg, 2)))
        else $error("byte reached firmware altered");

    a_fuse_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        (byte_event && !port_en_reg && !pop) |=> level == $past(level))
        else $error("byte stored while port disabled");

    a_reset_empty: assert property (
        @(posedge clk)
        !rst_n |=> level == '0 && !rd_valid && !fifo_space_flag_n)
        else $error("reset did not empty FIFO");

    sequence s_frame_start;
        link_pins.frame_sync && !sync_prev_reg;
    endsequence

    sequence s_seven_bits;
        (!(link_pins.frame_sync && !sync_prev_reg)) [*7];
    endsequence

    a_byte_after_sync: assert property (
        @(posedge serial_in_clock) disable iff (!lrst_n_s2_reg)
        s_frame_start ##1 s_seven_bits |=> $changed(done_tgl_reg))
        else $error("byte did not complete eight bits after frame sync");

    a_fuse_held: assert property (
        @(posedge clk)
        rst_n |=> port_en_reg == $past(port_en_reg))
        else $error("port enable changed outside reset");

    a_byte_crossing: assert property (
        @(posedge clk) disable iff (!rst_n)
        $changed(tgl_s1_reg) |=> byte_event ##1 !byte_event)
        else $error("byte toggle did not give a single write pulse");

    a_read_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_valid && !rd_ready) |=> rd_valid && $stable(rd_data))
        else $error("presented byte changed before it was taken");

endmodule : serial_slave_sync_receiver

//--- testbench/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
    output frame_sync_rx_pkg::link_pins_t link_pins,
    output logic                     serial_in_clock
);
    localparam int HALF_NS = 24;
    // Rise to rise spacing of data bits, a quarter of the system clock rate
    localparam int BIT_NS  = frame_sync_rx_pkg::CLK_RATIO_MIN * frame_sync_rx_pkg::SYS_PERIOD_NS;

    initial begin
        // Clock idles low outside frames, as while another port downloads
        serial_in_clock = 1'b0;
        link_pins       = '0;
    end

    // Only used around reset, so the link-side reset flops see edges
    task automatic run_clocks(input int n);
        repeat (n) begin
            link_pins.serial_data_in = ~link_pins.serial_data_in;
            #HALF_NS serial_in_clock = 1'b1;
            #HALF_NS serial_in_clock = 1'b0;
        end
    endtask : run_clocks

    // Clock stands low between frames; data moves only while it is low
    task automatic send_bits(input logic [7:0] value, input int nbits, input logic frame);
        for (int i = 7; i > 7 - nbits; i--) begin
            link_pins.serial_data_in = value[i];
            if (i == 7) link_pins.frame_sync = frame;
            // Low phase stretched so rising edges of data bits come BIT_NS apart
            #((i == 7) ? HALF_NS : BIT_NS - HALF_NS) serial_in_clock = 1'b1;
            #HALF_NS serial_in_clock = 1'b0;
            link_pins.frame_sync = 1'b0;
        end
        // Released line must not keep showing the last bit
        link_pins.serial_data_in = ~link_pins.serial_data_in;
        #(frame_sync_rx_pkg::MIN_GAP_NS + 400);
    endtask : send_bits
endmodule : host_link_model

//--- testbench/serial_slave_sync_receiver_bench.sv
`timescale 1ns/1ps
module serial_slave_sync_receiver_bench;
    logic                     clk;
    logic                     rst_n;
    logic                     fuse_serial_boot;
    logic                     rd_ready;
    logic                     rd_valid;
    logic                     fifo_space_flag_n;
    logic                     serial_in_clock;
    frame_sync_rx_pkg::link_pins_t link_pins;
    frame_sync_rx_pkg::byte_t      rd_data;
    int                       fail_count  = 0;
    int                       check_count = 0;
    int                       seed        = 14;
    int                       exp_q[$];

    host_link_model HOST (.link_pins(link_pins), .serial_in_clock(serial_in_clock));

    serial_slave_sync_receiver DUT (
        .clk              (clk),
        .rst_n            (rst_n),
        .serial_in_clock  (serial_in_clock),
        .link_pins        (link_pins),
        .fuse_serial_boot (fuse_serial_boot),
        .rd_ready         (rd_ready),
        .rd_valid         (rd_valid),
        .rd_data          (rd_data),
        .fifo_space_flag_n(fifo_space_flag_n)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    task automatic flag_check();
        check("space flag", 8'(fifo_space_flag_n),
              8'(exp_q.size() >= frame_sync_rx_pkg::SPACE_THRESH));
    endtask : flag_check

    task automatic do_reset(input logic fuse);
        @(negedge clk);
        rst_n            = 1'b0;
        fuse_serial_boot = fuse;
        exp_q.delete();
        fork
            HOST.run_clocks(8);
            repeat (5) @(negedge clk);
        join
        rst_n = 1'b1;
        HOST.run_clocks(3);
        check("rd_valid", 8'(rd_valid), 8'h00);
        flag_check();
    endtask : do_reset

    // Reference keeps only what a FIFO of the set depth can hold
    task automatic send(input logic [7:0] value, input logic frame);
        HOST.send_bits(value, 8, frame);
        if (fuse_serial_boot && exp_q.size() < frame_sync_rx_pkg::FIFO_DEPTH) begin
            exp_q.push_back(int'(value));
        end
        flag_check();
    endtask : send

    task automatic drain(input int n);
        int guard;
        guard = 0;
        while (n > 0 && guard < 4000) begin
            @(negedge clk);
            guard++;
            rd_ready = 1'($random(seed));
            if (rd_valid === 1'b1 && rd_ready) begin
                check("rd_data", rd_data, 8'(exp_q.pop_front()));
                n--;
            end
        end
        @(negedge clk);
        rd_ready = 1'b0;
        if (n > 0) begin
            fail_count++;
            $display("MISMATCH drain expected %0d more seen none", n);
            conclude();
        end
    endtask : drain

    initial begin
        #8_000_000;
        fail_count++;
        $display("MISMATCH watchdog expected finish seen hang");
        conclude();
    end

    initial begin
        rst_n            = 1'b0;
        fuse_serial_boot = 1'b0;
        rd_ready         = 1'b0;
        do_reset(1'b0);
        send(8'ha5, 1'b1);
        check("rd_valid", 8'(rd_valid), 8'h00);
        $display("test fuse_off done");
        do_reset(1'b1);
        // Partial byte must be thrown away by the next frame start
        HOST.send_bits(8'h0f, 3, 1'b1);
        for (int i = 0; i < 6; i++) send(8'($random(seed)), i == 0);
        drain(6);
        $display("test framing done");
        // Burst while space is shown, stopping once the flag rises
        while (fifo_space_flag_n === 1'b0 && exp_q.size() < frame_sync_rx_pkg::FIFO_DEPTH) begin
            send(8'($random(seed)), exp_q.size() == 0);
        end
        check("burst", 8'(exp_q.size()), 8'(frame_sync_rx_pkg::SPACE_THRESH));
        // Overrun on purpose: host now ignores the flag to reach a full FIFO
        for (int i = 0; i < 66; i++) send(8'($random(seed)), 1'b0);
        drain(65);
        repeat (4) @(negedge clk);
        flag_check();
        drain(exp_q.size());
        repeat (4) @(negedge clk);
        check("rd_valid", 8'(rd_valid), 8'h00);
        $display("test fill done");
        conclude();
    end
endmodule : serial_slave_sync_receiver_bench
